/* File: logic/gpio_pin_sense_drive_bits.sv */
/*
  Pin sense and drive logic for the low general-purpose pins, with an APB
  register slave, change detection, sticky change flags and one interrupt.
  Assumes pins are asynchronous to pclk and an APB master on pclk.
*/
// Contract
// - A read of a pin's input bit returns the pin level, and writes to it do nothing.
// - A pin in general-purpose output mode drives the last value written to its output bit.
// - A rising or falling level change on a pin sets that pin's change flag.
// - Writing one clears a change flag until the next change, and writing zero does nothing.
// - A level change on a pin also sets the system pin interrupt flag when that interrupt is enabled.
// - Pin n has input at bit 3n+2, output at 3n+1 and change flag at 3n, all resetting to zero.
// - A pin drives only when its select holds 111, and select 000 makes it a plain input.
// - An enabled system pin interrupt flag raises the request, and a disabled one does not.
`timescale 1ns/100ps
module gpio_pin_sense_drive_bits
  import gpio_pin_pkg::*;
#(
  parameter int NUM_PINS = PIN_COUNT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [SEL_W*NUM_PINS-1:0] sel_reg;
  logic [NUM_PINS-1:0] out_reg;
  logic [NUM_PINS-1:0] chg_reg;
  logic [NUM_PINS-1:0] chg_next;
  logic [NUM_PINS-1:0] int_flag_reg;
  logic [NUM_PINS-1:0] int_flag_next;
  logic [NUM_PINS-1:0] int_en_reg;
  logic [NUM_PINS-1:0] sync1_reg;
  logic [NUM_PINS-1:0] sync2_reg;
  logic [NUM_PINS-1:0] prev_reg;
  logic [PRIME_CYCLES-1:0] prime_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] rd_next;
  logic [NUM_PINS-1:0] change_det;
  logic mapped;
  logic setup_rd;
  logic wr_access;
  logic wr_sel;
  logic wr_cfg;
  logic wr_int_flag;
  logic wr_int_en;
  pin_field_type field;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  always_comb begin
    case (paddr)
      SEL_OFFSET, CFG_OFFSET, INT_FLAG_OFFSET, INT_EN_OFFSET: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr_access = psel & penable & pwrite & mapped;
  assign wr_sel = wr_access & (paddr == SEL_OFFSET);
  assign wr_cfg = wr_access & (paddr == CFG_OFFSET);
  assign wr_int_flag = wr_access & (paddr == INT_FLAG_OFFSET);
  assign wr_int_en = wr_access & (paddr == INT_EN_OFFSET);
  assign prdata = prdata_reg;

  // ----------------------------------------
  // Pin synchroniser and change detect
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
      prime_reg <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      prime_reg <= {prime_reg[PRIME_CYCLES-2:0], 1'b1};
    end
  end

  assign change_det = prime_reg[PRIME_CYCLES-1] ? (sync2_reg ^ prev_reg) : '0;

  // ----------------------------------------
  // Select, output and enable registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg <= '0;
      out_reg <= '0;
      int_en_reg <= '0;
    end else begin
      if (wr_sel) begin
        sel_reg <= pwdata[SEL_W*NUM_PINS-1:0];
      end
      if (wr_int_en) begin
        int_en_reg <= pwdata[NUM_PINS-1:0];
      end
      for (int i = 0; i < NUM_PINS; i++) begin
        if (wr_cfg) begin
          out_reg[i] <= pwdata[i*FIELD_STRIDE+OUT_POS];
        end
      end
    end
  end

  // ----------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      chg_next[i] = chg_reg[i];
      if (wr_cfg && pwdata[i*FIELD_STRIDE+CHG_POS]) begin
        chg_next[i] = 1'b0;
      end
      if (change_det[i]) begin
        chg_next[i] = 1'b1;
      end
      int_flag_next[i] = int_flag_reg[i];
      if (wr_int_flag && pwdata[i]) begin
        int_flag_next[i] = 1'b0;
      end
      if (change_det[i] && int_en_reg[i]) begin
        int_flag_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_reg <= '0;
      int_flag_reg <= '0;
    end else begin
      chg_reg <= chg_next;
      int_flag_reg <= int_flag_next;
    end
  end

  assign irq = |(int_flag_reg & int_en_reg);

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (sel_reg[i*SEL_W +: SEL_W] == SEL_GP_OUTPUT) begin
        pin_out[i] = out_reg[i];
        pin_oe_n[i] = 1'b0;
      end else begin
        pin_out[i] = 1'b0;
        pin_oe_n[i] = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------
  always_comb begin
    rd_next = RESET_WORD;
    field = '0;
    case (paddr)
      SEL_OFFSET: rd_next[SEL_W*NUM_PINS-1:0] = sel_reg;
      CFG_OFFSET: begin
        for (int i = 0; i < NUM_PINS; i++) begin
          field.input_level = sync2_reg[i];
          field.output_value = out_reg[i];
          field.change_flag = chg_reg[i];
          rd_next[i*FIELD_STRIDE +: FIELD_STRIDE] = field;
        end
      end
      INT_FLAG_OFFSET: rd_next[NUM_PINS-1:0] = int_flag_reg;
      INT_EN_OFFSET: rd_next[NUM_PINS-1:0] = int_en_reg;
      default: rd_next = RESET_WORD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= RESET_WORD;
    end else if (setup_rd) begin
      prdata_reg <= rd_next;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_sync_two_stage: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 sync2_reg == $past(pin_in, 2))
    else $error("pin level not taken through two stages");

  a_irq_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    (int_en_reg == '0) |-> !irq)
    else $error("interrupt raised with all enables off");

  for (genvar g = 0; g < NUM_PINS; g++) begin : gen_chk
    a_input_readback: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_rd && paddr == CFG_OFFSET) |=> prdata[g*FIELD_STRIDE+IN_POS] == $past(sync2_reg[g]))
      else $error("input bit does not show pin level");

    a_out_field: assert property (@(posedge pclk) disable iff (!presetn)
      (setup_rd && paddr == CFG_OFFSET) |=> prdata[g*FIELD_STRIDE+OUT_POS] == $past(out_reg[g])
        && prdata[g*FIELD_STRIDE+CHG_POS] == $past(chg_reg[g]))
      else $error("pin field out of place");

    a_drive_value: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cfg && sel_reg[g*SEL_W +: SEL_W] == SEL_GP_OUTPUT && !wr_sel)
        |=> pin_out[g] == $past(pwdata[g*FIELD_STRIDE+OUT_POS]) && !pin_oe_n[g])
      else $error("output pin not driving written value");

    a_input_mode: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_reg[g*SEL_W +: SEL_W] != SEL_GP_OUTPUT) |-> pin_oe_n[g] && !pin_out[g])
      else $error("pin driven outside output mode");

    a_change_set: assert property (@(posedge pclk) disable iff (!presetn)
      (prime_reg[PRIME_CYCLES-1] && $changed(sync2_reg[g]) && $past(prime_reg[PRIME_CYCLES-1]))
        |=> chg_reg[g])
      else $error("level change missed");

    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_cfg && pwdata[g*FIELD_STRIDE+CHG_POS] && !change_det[g]) ##1 !change_det[g][*2]
        |-> !chg_reg[g])
      else $error("change flag not cleared by write of one");

    a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (chg_reg[g] && !(wr_cfg && pwdata[g*FIELD_STRIDE+CHG_POS])) |=> chg_reg[g])
      else $error("change flag lost without clear");

    a_int_follow: assert property (@(posedge pclk) disable iff (!presetn)
      (change_det[g] && int_en_reg[g]) |=> int_flag_reg[g] ##0 irq)
      else $error("enabled change did not raise interrupt");
  end

endmodule

/* File: logic/gpio_pin_pkg.sv */
/*
  Shared constants and types for the pin sense and drive block: register
  offsets, field positions, select codes and reset values.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package gpio_pin_pkg;

  // ----------------------------------------
  // Bus and sizes
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PIN_COUNT = 5;
  localparam int SEL_W = 3;
  localparam int FIELD_STRIDE = 3;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] SEL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] CFG_OFFSET = 12'h00C;
  localparam logic [ADDR_W-1:0] INT_FLAG_OFFSET = 12'h018;
  localparam logic [ADDR_W-1:0] INT_EN_OFFSET = 12'h01C;

  // ----------------------------------------
  // Field positions inside one pin's group
  // ----------------------------------------
  localparam int CHG_POS = 0;
  localparam int OUT_POS = 1;
  localparam int IN_POS = 2;

  // ----------------------------------------
  // Function select codes
  // ----------------------------------------
  localparam logic [SEL_W-1:0] SEL_GP_INPUT = 3'h0;
  localparam logic [SEL_W-1:0] SEL_GP_OUTPUT = 3'h7;

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic RESET_BIT = 1'h0;
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
  localparam int PRIME_CYCLES = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic input_level;
    logic output_value;
    logic change_flag;
  } pin_field_type;

endpackage

/* File: verif/pin_far_side.sv */
/*
  Far-side model of the pins: the bench sets each external level.
  Assumes a driven pin (enable low) overrides the external level.
*/
`timescale 1ns/100ps
module pin_far_side (
  // From the block
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe_n,
  // From the bench
  input wire logic [4:0] ext_level,
  // To the block
  output logic [4:0] pin_in
);
  // ----------------------------------------
  // Wire level per pin
  // ----------------------------------------
  always_comb begin
    for (int n = 0; n < 5; n++) begin
      pin_in[n] = pin_oe_n[n] ? ext_level[n] : pin_out[n];
    end
  end
endmodule

/* File: verif/test_gpio_pin_sense_drive_bits.sv */
/*
  Directed bench: APB register tasks, pin stimulus, interrupt checks.
  Assumes a zero wait state slave and flags set three edges after a pin change.
*/
`timescale 1ns/100ps
module test_gpio_pin_sense_drive_bits;
  import gpio_pin_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [4:0] pin_in, pin_out, pin_oe_n, ext_level;
  int miscompares = 0;
  int samples_checked = 0;

  gpio_pin_sense_drive_bits i_gpio_pin_sense_drive_bits (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
  pin_far_side i_pin_far_side (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level), .pin_in(pin_in));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd_data,
                     output logic err);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      miscompares++;
      wrap_up();
    end
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  // Output picked at the falling edge, when it has settled
  localparam int LOOK_IRQ = 0;
  localparam int LOOK_OUT = 1;
  localparam int LOOK_OE = 2;

  task automatic look(input int what, input logic [31:0] exp);
    logic [31:0] got;
    @(negedge pclk);
    if (what == LOOK_IRQ) begin
      got = {31'h0, irq};
    end else if (what == LOOK_OUT) begin
      got = {27'h0, pin_out};
    end else begin
      got = {27'h0, pin_oe_n};
    end
    chk(got, exp);
    @(posedge pclk);
  endtask

  task automatic pins(input logic [4:0] v);
    ext_level <= v;
    repeat (6) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_values();
    rd(CFG_OFFSET, 32'h0000_0000);
    rd(SEL_OFFSET, 32'h0000_0000);
    look(LOOK_OE, 32'h0000_001F);
    look(LOOK_IRQ, 32'h0000_0000);
  endtask

  task automatic sense_and_flags();
    pins(5'h15);
    rd(CFG_OFFSET, 32'h0000_5145);
    rd(INT_FLAG_OFFSET, 32'h0000_0000);
    look(LOOK_IRQ, 32'h0000_0000);
    wr(CFG_OFFSET, 32'h0000_1249);
    rd(CFG_OFFSET, 32'h0000_4104);
  endtask

  task automatic interrupt_path();
    wr(INT_EN_OFFSET, 32'h0000_001F);
    ext_level <= 5'h00;
    look(LOOK_IRQ, 32'h0000_0000);
    repeat (5) @(posedge pclk);
    look(LOOK_IRQ, 32'h0000_0001);
    rd(INT_FLAG_OFFSET, 32'h0000_0015);
    wr(CFG_OFFSET, 32'h0000_0000);
    rd(CFG_OFFSET, 32'h0000_1041);
    wr(INT_FLAG_OFFSET, 32'h0000_0015);
    look(LOOK_IRQ, 32'h0000_0000);
    wr(INT_EN_OFFSET, 32'h0000_0000);
    wr(CFG_OFFSET, 32'h0000_1249);
    pins(5'h01);
    look(LOOK_IRQ, 32'h0000_0000);
    rd(CFG_OFFSET, 32'h0000_0005);
  endtask

  task automatic drive_path();
    wr(CFG_OFFSET, 32'h0000_7FFF);
    wr(SEL_OFFSET, 32'h0000_0038);
    repeat (6) @(posedge pclk);
    look(LOOK_OUT, 32'h0000_0002);
    look(LOOK_OE, 32'h0000_001D);
    rd(CFG_OFFSET, 32'h0000_24BE);
    // Rewrite the output bit while the pin is in output mode
    wr(CFG_OFFSET, 32'h0000_0008);
    look(LOOK_OUT, 32'h0000_0000);
    look(LOOK_OE, 32'h0000_001D);
    wr(SEL_OFFSET, 32'h0000_0030);
    look(LOOK_OUT, 32'h0000_0000);
    look(LOOK_OE, 32'h0000_001F);
  endtask

  task automatic unmapped_access();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h040, 32'h0, r, e);
    chk(r, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ext_level = 5'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    reset_values();
    sense_and_flags();
    interrupt_path();
    drive_path();
    unmapped_access();
    wrap_up();
  end
endmodule
